// ### iosr_readout.sv
// I/O status readout command handler: parses the terminal command, streams reports
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iosr_readout (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Terminal receive byte stream (same clock)
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    // Terminal transmit byte stream (same clock)
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Control connector levels, active high
    input  wire logic        servo_on_input,
    input  wire logic        emergency_stop_input,
    input  wire logic        run_input,
    input  wire logic        home_limit_input,
    input  wire logic        program_select_bit3,
    input  wire logic        program_select_bit2,
    input  wire logic        program_select_bit1,
    input  wire logic        program_select_bit0,
    input  wire logic        direction_input,
    input  wire logic        jog_input,
    input  wire logic        minus_travel_limit_input,
    input  wire logic        plus_travel_limit_input,
    input  wire logic        home_start_input,
    input  wire logic        error_counter_clear_input,
    input  wire logic        driver_ready_output,
    input  wire logic        brake_output,
    input  wire logic        in_position_output
);
    localparam int PIN_W = 17;

    logic [PIN_W-1:0]          pins_s;
    logic [iosr_pkg::TYPE_W-1:0] io_type_r;
    iosr_pkg::iosr_state_t     state_r;
    logic [3:0]                idx_r;
    logic [7:0]                tx_data_r;
    logic [iosr_pkg::SNAP_W-1:0] snap_r;
    logic                      repeat_r;
    logic                      pend_r;
    logic [2:0]                len_r;
    logic [39:0]               line_r;
    logic [31:0]               prdata_r;

    // Pins are asynchronous to pclk, so all pass two flops first
    iosr_sync #(.W(PIN_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({servo_on_input, emergency_stop_input, run_input, home_limit_input,
                   program_select_bit3, program_select_bit2, program_select_bit1,
                   program_select_bit0, direction_input, jog_input,
                   minus_travel_limit_input, plus_travel_limit_input, home_start_input,
                   error_counter_clear_input, driver_ready_output, brake_output,
                   in_position_output}),
        .q       (pins_s)
    );

    // Lower input nibble by I/O type; unknown types fall back to type 1
    function automatic logic [3:0] low_nibble(input logic [2:0] ty, input logic [PIN_W-1:0] p);
        logic [3:0] r;
        r = p[12:9];
        case (ty)
            iosr_pkg::TY2: r = {p[12], p[11], p[8], p[7]};
            iosr_pkg::TY3: r = {p[12], p[11], p[6], p[5]};
            iosr_pkg::TY4: r = {p[4], p[3], p[6], p[5]};
            iosr_pkg::TY7: r = {p[8], p[7], p[6], p[5]};
            default:       r = p[12:9];
        endcase
        return r;
    endfunction : low_nibble

    // ASCII digit for one status bit
    function automatic logic [7:0] digit(input logic b);
        return b ? iosr_pkg::CH_ONE : iosr_pkg::CH_ZERO;
    endfunction : digit

    // Character at a report position
    function automatic logic [7:0] char_at(input logic [3:0] ix,
                                           input logic [iosr_pkg::SNAP_W-1:0] s);
        logic [7:0] c;
        c = iosr_pkg::CH_SPACE;
        if (ix == iosr_pkg::IX_CR)
            c = iosr_pkg::CH_CR;
        else if (ix >= iosr_pkg::IX_OUT0)
            c = digit(s[4'(iosr_pkg::IX_CR - 4'h1 - ix)]);
        else if (ix >= iosr_pkg::IX_IN0 && ix < iosr_pkg::IX_SEP)
            c = digit(s[4'(iosr_pkg::IX_CR - 4'h2 - ix)]);
        return c;
    endfunction : char_at

    // Live snapshot: upper inputs fixed, lower by type, outputs, unused slot
    wire [iosr_pkg::SNAP_W-1:0] snap_now = {pins_s[16:13], low_nibble(io_type_r, pins_s),
                                            pins_s[2:0], 1'b0};

    // Command decode on enter
    wire rx_cr      = rx_valid && (rx_data == iosr_pkg::CH_CR);
    wire rx_bs      = rx_valid && (rx_data == iosr_pkg::CH_BS);
    wire is_plain   = (len_r == iosr_pkg::LEN_PLAIN) &&
                      (line_r[15:0] == {iosr_pkg::CH_I, iosr_pkg::CH_O});
    wire is_repeat  = (len_r == iosr_pkg::LEN_REPEAT) &&
                      (line_r == {iosr_pkg::CH_I, iosr_pkg::CH_O, iosr_pkg::CH_SLASH,
                                  iosr_pkg::CH_R, iosr_pkg::CH_P});
    wire cmd_ok     = rx_cr && (is_plain || is_repeat);

    // Transmit sequencing
    wire idle       = (state_r == iosr_pkg::IOSR_IDLE);
    wire start      = idle && (pend_r || repeat_r);
    wire [3:0] first_w = repeat_r ? iosr_pkg::IX_LEAD : iosr_pkg::IX_IN0;
    wire tx_fire    = tx_valid && tx_ready;
    wire last_char  = tx_fire && (idx_r == iosr_pkg::IX_CR);
    wire [3:0] idx_nxt = idx_r + 4'h1;

    assign tx_valid = (state_r == iosr_pkg::IOSR_SEND);
    assign tx_data  = tx_data_r;

    // APB decode: zero-wait slave, error on unmapped offsets
    wire apb_acc    = psel && penable;
    wire hit_ctrl   = (paddr == iosr_pkg::CTRL_OFS);
    wire hit_stat   = (paddr == iosr_pkg::STATUS_OFS);
    wire ctrl_wr    = apb_acc && pwrite && hit_ctrl;
    wire [31:0] rd_mux = hit_ctrl ? {29'h0, io_type_r} :
                         hit_stat ? {12'h0, snap_r, 6'h0, repeat_r, ~idle} : 32'h0;
    assign pready   = 1'b1;
    assign pslverr  = apb_acc && !(hit_ctrl || (hit_stat && !pwrite));
    assign prdata   = prdata_r;

    // Line editor: keeps the last five characters and counts those since the previous enter or backspace
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r  <= 3'h0;
            line_r <= 40'h0;
        end else if (rx_cr || rx_bs) begin
            len_r  <= 3'h0;
        end else if (rx_valid) begin
            line_r <= {line_r[31:0], rx_data};
            len_r  <= (len_r == 3'h7) ? len_r : len_r + 3'h1;
        end
    end

    // Request flags; a new command arriving with the backspace cannot collide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_r <= 1'b0;
            pend_r   <= 1'b0;
        end else begin
            if (rx_bs)
                repeat_r <= 1'b0;
            else if (cmd_ok)
                repeat_r <= is_repeat;
            if (cmd_ok && is_plain)
                pend_r <= 1'b1;
            else if (start)
                pend_r <= 1'b0;
        end
    end

    // Report sender; snapshot taken fresh at every report start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= iosr_pkg::IOSR_IDLE;
            idx_r     <= iosr_pkg::IX_LEAD;
            tx_data_r <= iosr_pkg::CH_SPACE;
            snap_r    <= '0;
        end else begin
            case (state_r)
                iosr_pkg::IOSR_IDLE: begin
                    if (start) begin
                        snap_r    <= snap_now;
                        idx_r     <= first_w;
                        tx_data_r <= char_at(first_w, snap_now);
                        state_r   <= iosr_pkg::IOSR_SEND;
                    end
                end
                iosr_pkg::IOSR_SEND: begin
                    if (last_char) begin
                        state_r <= iosr_pkg::IOSR_IDLE;         // Repeat restarts from idle
                    end else if (tx_fire) begin
                        idx_r     <= idx_nxt;
                        tx_data_r <= char_at(idx_nxt, snap_r);
                    end
                end
                default: state_r <= iosr_pkg::IOSR_IDLE;
            endcase
        end
    end

    // Control register write and registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_type_r <= iosr_pkg::TYPE_RST;
            prdata_r  <= 32'h0;
        end else begin
            if (ctrl_wr)
                io_type_r <= pwdata[iosr_pkg::TYPE_LSB +: iosr_pkg::TYPE_W];
            if (psel && !penable && !pwrite)
                prdata_r <= rd_mux;
        end
    end

endmodule : iosr_readout
`default_nettype wire

// ### iosr_pkg.sv
// Shared constants for the I/O status readout command handler
`default_nettype none
package iosr_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    // Control register fields and reset value
    localparam int         TYPE_LSB    = 0;
    localparam int         TYPE_W      = 3;
    localparam logic [2:0] TYPE_RST    = 3'h1;
    // Status register field positions
    localparam int         ST_BUSY     = 0;
    localparam int         ST_REPEAT   = 1;
    localparam int         ST_SNAP_LSB = 8;
    // I/O type codes
    localparam logic [2:0] TY1         = 3'h1;
    localparam logic [2:0] TY2         = 3'h2;
    localparam logic [2:0] TY3         = 3'h3;
    localparam logic [2:0] TY4         = 3'h4;
    localparam logic [2:0] TY7         = 3'h7;
    // Character codes
    localparam logic [7:0] CH_SPACE    = 8'h20;
    localparam logic [7:0] CH_CR       = 8'h0d;
    localparam logic [7:0] CH_BS       = 8'h08;
    localparam logic [7:0] CH_ZERO     = 8'h30;
    localparam logic [7:0] CH_ONE      = 8'h31;
    localparam logic [7:0] CH_I        = 8'h49;
    localparam logic [7:0] CH_O        = 8'h4f;
    localparam logic [7:0] CH_SLASH    = 8'h2f;
    localparam logic [7:0] CH_R        = 8'h52;
    localparam logic [7:0] CH_P        = 8'h50;
    // Report layout: index 0 leading space, 1..8 inputs, 9 separator,
    // 10..13 outputs, 14 carriage return
    localparam logic [3:0] IX_LEAD     = 4'h0;
    localparam logic [3:0] IX_IN0      = 4'h1;
    localparam logic [3:0] IX_SEP      = 4'h9;
    localparam logic [3:0] IX_OUT0     = 4'ha;
    localparam logic [3:0] IX_CR       = 4'he;
    localparam int         SNAP_W      = 12;
    // Command lengths
    localparam logic [2:0] LEN_PLAIN   = 3'h2;
    localparam logic [2:0] LEN_REPEAT  = 3'h5;
    // Transmit sequencer states
    typedef enum logic [1:0] {
        IOSR_IDLE = 2'b01,
        IOSR_SEND = 2'b10
    } iosr_state_t;
endpackage : iosr_pkg
`default_nettype wire

// ### iosr_sync.sv
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
`default_nettype none
module iosr_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Elaboration-time refusal of a width the flops cannot hold
    if (W < 1) begin : g_bad_width
        $error("iosr_sync width must be positive");
    end

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : iosr_sync
`default_nettype wire

// ### iosr_readout_asserts.sv
// Port-level assertion checker for the I/O status readout handler
`timescale 1ns/1ps
`default_nettype none
module iosr_readout_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pslverr,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [39:0] hist_r;
    logic [3:0]  cnt_r;
    logic [15:0] line_r;
    logic [2:0]  len_r;
    logic        bs_r;
    // Handshake and special-character decodes
    wire tk  = tx_valid && tx_ready;
    wire crt = tk && tx_data == iosr_pkg::CH_CR;
    wire rcr = rx_valid && rx_data == iosr_pkg::CH_CR;
    wire rbs = rx_valid && rx_data == iosr_pkg::CH_BS;
    // Last five sent chars, chars per report and the typed line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hist_r, cnt_r, line_r, len_r, bs_r} <= '0;
        end else begin
            if (tk) hist_r <= {hist_r[31:0], tx_data};
            if (tk) cnt_r <= crt ? 4'h0 : cnt_r + 4'h1;
            if (rx_valid) line_r <= {line_r[7:0], rx_data};
            // Saturate like the line editor so long lines never alias a short one
            if (rx_valid) len_r <= (rcr || rbs) ? 3'h0 :
                                   (len_r == 3'h7) ? len_r : len_r + 3'h1;
            // A stop request stays armed until a new line is entered
            if (rbs || rcr) bs_r <= rbs;
        end
    end
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before it was taken");
    AST_CHARSET: assert property (tx_valid |-> tx_data inside {8'h20, 8'h0d, 8'h30, 8'h31})
        else $error("tx byte outside the report alphabet");
    AST_LEN: assert property (crt |-> cnt_r == 4'hd || cnt_r == 4'he)
        else $error("report length wrong");
    AST_SEP: assert property (crt |-> hist_r[39:32] == iosr_pkg::CH_SPACE)
        else $error("separator missing before outputs");
    AST_UNUSED: assert property (crt |-> hist_r[7:0] == iosr_pkg::CH_ZERO)
        else $error("unused output position not zero");
    AST_GAP: assert property (crt |=> !tx_valid)
        else $error("no idle cycle after report");
    AST_START: assert property (rcr && len_r == 3'h2 && line_r == 16'h494f && !tx_valid
        |-> ##2 tx_valid)
        else $error("command not answered in two cycles");
    AST_BS: assert property (bs_r && crt |=> !tx_valid [*4])
        else $error("reporting went on after backspace");
    AST_RO: assert property (psel && penable && pwrite && paddr == iosr_pkg::STATUS_OFS
        |-> pslverr)
        else $error("status write not refused");
endmodule : iosr_readout_asserts
`default_nettype wire

// ### iosr_term.sv
// Handheld terminal model on the byte link
`timescale 1ns/1ps
`default_nettype none
module iosr_term (
    input  wire logic       pclk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var logic        tx_ready,
    output var logic [7:0]  rx_data,
    output var logic        rx_valid
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    initial tx_ready = 1'b1;
    initial rx_data = 8'h00;
    initial rx_valid = 1'b0;
    // Keep every byte taken; a slow terminal stalls every other cycle
    always @(posedge pclk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // One key per call; the released line shows the inverse byte
    task automatic send(input logic [7:0] b);
        @(posedge pclk);
        rx_data <= b;
        rx_valid <= 1'b1;
        @(posedge pclk);
        rx_data <= ~b;
        rx_valid <= 1'b0;
    endtask : send
endmodule : iosr_term
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the I/O status readout handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00, tx_data, rx_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tx_valid, tx_ready, rx_valid;
    logic [16:0] pv = 17'h0;
    logic [7:0] e[$];
    logic [2:0] tys[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [11:0] es;
    int num_errors = 0, checks_done = 0;
    iosr_readout i_iosr_readout (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .servo_on_input(pv[16]), .emergency_stop_input(pv[15]),
        .run_input(pv[14]), .home_limit_input(pv[13]), .program_select_bit3(pv[12]),
        .program_select_bit2(pv[11]), .program_select_bit1(pv[10]),
        .program_select_bit0(pv[9]), .direction_input(pv[8]), .jog_input(pv[7]),
        .minus_travel_limit_input(pv[6]), .plus_travel_limit_input(pv[5]),
        .home_start_input(pv[4]), .error_counter_clear_input(pv[3]),
        .driver_ready_output(pv[2]), .brake_output(pv[1]), .in_position_output(pv[0]));
    iosr_term i_term (.pclk(pclk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    initial forever #12.5 pclk = ~pclk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready && ++k < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (!pready) begin num_errors++; wrap_up(); end
        // Idle edge so a following call never re-drives psel in this time step
        @(posedge pclk);
    endtask : apb
    task automatic got_n(input int n);
        int k = 0;
        while (i_term.got.size() < n && k++ < 3000) @(posedge pclk);
        if (i_term.got.size() < n) begin num_errors++; wrap_up(); end
    endtask : got_n
    task automatic cmd(input string s);
        for (int i = 0; i < s.len(); i++) i_term.send(s[i]);
        i_term.send(iosr_pkg::CH_CR);
    endtask : cmd
    // Expected report from the pin levels and the I/O type
    task automatic exp_rep(input logic [2:0] ty, input logic rep);
        logic [3:0] nb;
        case (ty)
            iosr_pkg::TY2: nb = {pv[12:11], pv[8:7]};
            iosr_pkg::TY3: nb = {pv[12:11], pv[6:5]};
            iosr_pkg::TY4: nb = {pv[4:3], pv[6:5]};
            iosr_pkg::TY7: nb = pv[8:5];
            default: nb = pv[12:9];
        endcase
        es = {pv[16:13], nb, pv[2:0], 1'b0};
        e.delete();
        if (rep) e.push_back(iosr_pkg::CH_SPACE);
        for (int i = 11; i >= 0; i--) begin
            if (i == 3) e.push_back(iosr_pkg::CH_SPACE);
            e.push_back(es[i] ? iosr_pkg::CH_ONE : iosr_pkg::CH_ZERO);
        end
        e.push_back(iosr_pkg::CH_CR);
    endtask : exp_rep
    task automatic cmp(input int off);
        for (int i = 0; i < e.size(); i++) `CHK("tx char", e[i], i_term.got[off + i])
    endtask : cmp
    task automatic t_regs();
        apb(1'b0, iosr_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl reset", {29'h0, iosr_pkg::TYPE_RST}, rd)
        apb(1'b1, iosr_pkg::STATUS_OFS, 32'hffff);
        `CHK("status write err", 1'b1, er)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("unmapped read", 33'h100000000, {er, rd})
        $display("register test done");
    endtask : t_regs
    // Wrong case, wrong name and a cancelled line give no output
    task automatic t_junk();
        i_term.got.delete();
        cmd("IX");
        cmd("io");
        i_term.send(iosr_pkg::CH_I);
        i_term.send(iosr_pkg::CH_O);
        i_term.send(iosr_pkg::CH_BS);
        cmd("");
        repeat (40) @(posedge pclk);
        `CHK("junk output", 0, i_term.got.size())
        $display("junk command test done");
    endtask : t_junk
    task automatic t_single(input logic [2:0] ty, input logic [16:0] p);
        apb(1'b1, iosr_pkg::CTRL_OFS, {29'h0, ty});
        pv <= p;
        i_term.slow <= (ty == iosr_pkg::TY4);
        repeat (4) @(posedge pclk);
        i_term.got.delete();
        cmd("IO");
        got_n(14);
        repeat (40) @(posedge pclk);
        exp_rep(ty, 1'b0);
        cmp(0);
        `CHK("single len", 14, i_term.got.size())
        $display("single report type %0d done", ty);
    endtask : t_single
    // Repeated reports follow a pin change and stop on backspace
    task automatic t_repeat();
        int n;
        pv <= 17'h0a5a5;
        repeat (4) @(posedge pclk);
        i_term.got.delete();
        cmd("IO/RP");
        got_n(15);
        exp_rep(iosr_pkg::TY7, 1'b1);
        cmp(0);
        pv <= 17'h15a5a;
        apb(1'b0, iosr_pkg::STATUS_OFS, 32'h0);
        `CHK("repeat flag", 1'b1, rd[iosr_pkg::ST_REPEAT])
        got_n(45);
        exp_rep(iosr_pkg::TY7, 1'b1);
        cmp(30);
        i_term.send(iosr_pkg::CH_BS);
        repeat (60) @(posedge pclk);
        n = i_term.got.size();
        `CHK("whole reports", 0, n % 15)
        repeat (60) @(posedge pclk);
        `CHK("stopped", n, i_term.got.size())
        apb(1'b0, iosr_pkg::STATUS_OFS, 32'h0);
        `CHK("status idle", {12'h0, es, 8'h00}, rd)
        $display("repeat report test done");
    endtask : t_repeat
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_junk();
        for (int i = 0; i < 6; i++) t_single(tys[i], 17'h1b4e3 ^ (17'h05a3c << i));
        t_repeat();
        wrap_up();
    end
endmodule : tb
bind iosr_readout iosr_readout_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
`default_nettype wire
